// ===== hw/hcnt_pkg.sv
// What this block does
// - mode definition accepted once per counter after entering run state; setup then fixed.
// - repeated definition raises a run-time error and leaves setup unchanged.
// - one update command applies direction, current and preset together in any mix.
// - modes 0,1,2 single phase, software direction; none, reset, reset plus start.
// - modes 3,4,5 single phase, external direction; none, reset, reset plus start.
// - modes 6,7,8 separate up and down clocks; none, reset, reset plus start.
// - modes 9,10,11 A/B quadrature; none, reset, reset plus start.
// - event 13 raised when current becomes equal to preset, in every mode.
// - event 14 raised on direction change in all modes except 0,1,2.
// - event 15 raised when the external reset becomes active, in reset modes.
// - control byte F8 enables, loads current and preset, counts up, 4x, high.
// - control byte FC is like F8 but quadrature counts at 1x rate.
// - events reach handlers only once attached and global enable is set.
// - staged byte bits 7..3, current and preset take effect only on the update command.
// - control bit 7 enable, 6 load current, 5 load preset, 4 dir update, 3 up.
// - config bit 2 picks 4x (0) or 1x (1), sampled only at definition.
// - status bit 5 direction up, bit 6 equal, bit 7 greater than preset.
// - current and preset are 32-bit signed values.
package hcnt_pkg;

    localparam int unsigned AXI_ADDR_W   = 8;
    localparam int unsigned DATA_W       = 32;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_NEW_CUR  = 8'h04;
    localparam logic [7:0]  OFF_NEW_PRE  = 8'h08;
    localparam logic [7:0]  OFF_UPDATE   = 8'h0C;
    localparam logic [7:0]  OFF_DEFINE   = 8'h10;
    localparam logic [7:0]  OFF_SYS      = 8'h14;
    localparam logic [7:0]  OFF_STATUS   = 8'h18;
    localparam logic [7:0]  OFF_CURRENT  = 8'h1C;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned CB_ENABLE    = 7;
    localparam int unsigned CB_LOAD_CUR  = 6;
    localparam int unsigned CB_LOAD_PRE  = 5;
    localparam int unsigned CB_DIR_UPD   = 4;
    localparam int unsigned CB_DIR_UP    = 3;
    localparam int unsigned CB_RATE_1X   = 2;
    localparam int unsigned CB_START_LOW = 1;
    localparam int unsigned CB_RESET_LOW = 0;

    localparam int unsigned ST_DIR       = 5;
    localparam int unsigned ST_EQ        = 6;
    localparam int unsigned ST_GT        = 7;
    localparam int unsigned ST_DEFINED   = 8;
    localparam int unsigned ST_ERROR     = 9;
    localparam int unsigned ST_ENABLED   = 10;
    localparam int unsigned ST_MODE_LSB  = 16;

    localparam int unsigned SYS_RUN      = 0;
    localparam int unsigned SYS_GIE      = 1;
    localparam int unsigned SYS_ATT_EQ   = 13;
    localparam int unsigned SYS_ATT_DIR  = 14;
    localparam int unsigned SYS_ATT_RST  = 15;

    localparam int unsigned DEF_MODE_LSB = 0;

    // ----------------------------------------------------------------
    // reset values and codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [31:0] HOLD_RST     = 32'h0000_0000;
    localparam logic [31:0] SYS_RST      = 32'h0000_0000;
    localparam logic [3:0]  MODE_RST     = 4'h0;
    localparam logic [3:0]  MODE_MAX     = 4'hB;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        HCNT_INT_DIR,
        HCNT_EXT_DIR,
        HCNT_TWO_CLK,
        HCNT_QUAD
    } hcnt_kind_t;

    typedef struct packed {
        logic [3:0] mode;
        logic       rate_1x;
        logic       start_low;
        logic       reset_low;
    } hcnt_cfg_t;

    typedef struct packed {
        logic phase_a;
        logic phase_b;
        logic ext_reset;
        logic ext_start;
    } hcnt_pins_t;

endpackage

// ===== hw/hcnt_sync.sv
`timescale 1ns/1ps
module hcnt_sync #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] raw_i,
    output logic      [WIDTH-1:0] stable_o
);
    // ----------------------------------------------------------------
    // three stages, accept once stages two and three agree
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= raw_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stable_o <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    stable_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// ===== hw/hcnt_top.sv
`timescale 1ns/1ps
module hcnt_top (
    input  wire logic                               mclk_i,
    input  wire logic                               rst_n_i,
    input  wire logic [hcnt_pkg::AXI_ADDR_W-1:0]    s_axi_awaddr_i,
    input  wire logic                               s_axi_awvalid_i,
    output logic                                    s_axi_awready_o,
    input  wire logic [hcnt_pkg::DATA_W-1:0]        s_axi_wdata_i,
    input  wire logic [hcnt_pkg::DATA_W/8-1:0]      s_axi_wstrb_i,
    input  wire logic                               s_axi_wvalid_i,
    output logic                                    s_axi_wready_o,
    output logic [1:0]                              s_axi_bresp_o,
    output logic                                    s_axi_bvalid_o,
    input  wire logic                               s_axi_bready_i,
    input  wire logic [hcnt_pkg::AXI_ADDR_W-1:0]    s_axi_araddr_i,
    input  wire logic                               s_axi_arvalid_i,
    output logic                                    s_axi_arready_o,
    output logic [hcnt_pkg::DATA_W-1:0]             s_axi_rdata_o,
    output logic [1:0]                              s_axi_rresp_o,
    output logic                                    s_axi_rvalid_o,
    input  wire logic                               s_axi_rready_i,
    input  wire hcnt_pkg::hcnt_pins_t               pins_i,
    output logic                                    evt_cv_eq_pv_o,
    output logic                                    evt_dir_chg_o,
    output logic                                    evt_ext_rst_o
);
    import hcnt_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [3:0]            pin_vec;
    hcnt_pins_t            pin;
    hcnt_pins_t            pin_prev_q;
    logic [7:0]            ctrl_q;
    logic [31:0]           new_cur_q;
    logic [31:0]           new_pre_q;
    logic [31:0]           sys_q;
    hcnt_cfg_t             cfg_q;
    logic                  defined_q;
    logic                  err_q;
    logic                  en_q;
    logic                  dir_q;
    logic                  dir_d;
    logic signed [31:0]    count_q;
    logic signed [31:0]    count_d;
    logic signed [31:0]    preset_q;
    logic signed [31:0]    preset_d;
    logic                  eq_q;
    logic                  gt_q;
    logic                  aw_got_q;
    logic                  w_got_q;
    logic [7:0]            aw_addr_q;
    logic [31:0]           w_data_q;
    logic [3:0]            w_strb_q;
    logic                  aw_take;
    logic                  w_take;
    logic                  ar_take;
    logic                  wr_fire;
    logic                  aw_got_nx;
    logic                  w_got_nx;
    logic                  bvalid_nx;
    logic                  rvalid_nx;
    logic                  upd_cmd;
    logic                  def_cmd;
    logic                  def_bad;
    logic                  err_clr;
    logic [3:0]            def_mode;
    hcnt_kind_t            kind;
    logic                  use_rst;
    logic                  use_start;
    logic                  rst_act;
    logic                  rst_act_prev;
    logic                  start_ok;
    logic                  active;
    logic                  a_rise;
    logic                  b_rise;
    logic                  a_chg;
    logic                  b_chg;
    logic                  step_up;
    logic                  step_dn;
    logic                  eq_d;
    logic                  ev_eq;
    logic                  ev_dir;
    logic                  ev_rst;
    logic [31:0]           rd_word;
    logic                  rd_ok;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    hcnt_sync #(
        .WIDTH (4)
    ) u_sync (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .raw_i    (pins_i),
        .stable_o (pin_vec)
    );

    assign pin = hcnt_pins_t'(pin_vec);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFF_CURRENT);
    endfunction

    // ----------------------------------------------------------------
    // axi write channel
    // ----------------------------------------------------------------
    assign aw_take   = s_axi_awvalid_i & s_axi_awready_o;
    assign w_take    = s_axi_wvalid_i & s_axi_wready_o;
    assign wr_fire   = aw_got_q & w_got_q;
    assign aw_got_nx = wr_fire ? 1'b0 : (aw_got_q | aw_take);
    assign w_got_nx  = wr_fire ? 1'b0 : (w_got_q | w_take);
    assign bvalid_nx = wr_fire | (s_axi_bvalid_o & ~s_axi_bready_i);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_got_q        <= 1'b0;
            w_got_q         <= 1'b0;
            aw_addr_q       <= 8'h00;
            w_data_q        <= 32'h0000_0000;
            w_strb_q        <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= RESP_OKAY;
        end else begin
            aw_got_q        <= aw_got_nx;
            w_got_q         <= w_got_nx;
            s_axi_awready_o <= ~aw_got_nx & ~bvalid_nx;
            s_axi_wready_o  <= ~w_got_nx & ~bvalid_nx;
            s_axi_bvalid_o  <= bvalid_nx;
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr_i;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata_i;
                w_strb_q <= s_axi_wstrb_i;
            end
            if (wr_fire) begin
                s_axi_bresp_o <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // staging registers and commands
    // ----------------------------------------------------------------
    assign upd_cmd  = wr_fire && (aw_addr_q == OFF_UPDATE) && w_strb_q[0];
    assign def_cmd  = wr_fire && (aw_addr_q == OFF_DEFINE) && w_strb_q[0];
    assign def_mode = w_data_q[DEF_MODE_LSB +: 4];
    assign def_bad  = def_cmd && (defined_q || !sys_q[SYS_RUN] || def_mode > MODE_MAX);
    assign err_clr  = wr_fire && (aw_addr_q == OFF_STATUS) && w_strb_q[1] && w_data_q[ST_ERROR];

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q    <= CTRL_RST;
            new_cur_q <= HOLD_RST;
            new_pre_q <= HOLD_RST;
            sys_q     <= SYS_RST;
        end else if (wr_fire) begin
            unique case (aw_addr_q)
                OFF_CTRL:    if (w_strb_q[0]) ctrl_q <= w_data_q[7:0];
                OFF_NEW_CUR: new_cur_q <= merge(new_cur_q, w_data_q, w_strb_q);
                OFF_NEW_PRE: new_pre_q <= merge(new_pre_q, w_data_q, w_strb_q);
                OFF_SYS:     sys_q <= merge(sys_q, w_data_q, w_strb_q);
                default:     ;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q     <= '{mode: MODE_RST, rate_1x: 1'b0, start_low: 1'b0, reset_low: 1'b0};
            defined_q <= 1'b0;
            err_q     <= 1'b0;
        end else begin
            err_q <= def_bad | (err_q & ~err_clr);
            if (!sys_q[SYS_RUN]) begin
                defined_q <= 1'b0;
            end else if (def_cmd && !def_bad) begin
                defined_q       <= 1'b1;
                cfg_q.mode      <= def_mode;
                cfg_q.rate_1x   <= ctrl_q[CB_RATE_1X];
                cfg_q.start_low <= ctrl_q[CB_START_LOW];
                cfg_q.reset_low <= ctrl_q[CB_RESET_LOW];
            end
        end
    end

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    always_comb begin
        kind      = HCNT_INT_DIR;
        use_rst   = 1'b0;
        use_start = 1'b0;
        unique case (cfg_q.mode)
            4'h0: kind = HCNT_INT_DIR;
            4'h1: begin kind = HCNT_INT_DIR; use_rst = 1'b1; end
            4'h2: begin kind = HCNT_INT_DIR; use_rst = 1'b1; use_start = 1'b1; end
            4'h3: kind = HCNT_EXT_DIR;
            4'h4: begin kind = HCNT_EXT_DIR; use_rst = 1'b1; end
            4'h5: begin kind = HCNT_EXT_DIR; use_rst = 1'b1; use_start = 1'b1; end
            4'h6: kind = HCNT_TWO_CLK;
            4'h7: begin kind = HCNT_TWO_CLK; use_rst = 1'b1; end
            4'h8: begin kind = HCNT_TWO_CLK; use_rst = 1'b1; use_start = 1'b1; end
            4'h9: kind = HCNT_QUAD;
            4'hA: begin kind = HCNT_QUAD; use_rst = 1'b1; end
            4'hB: begin kind = HCNT_QUAD; use_rst = 1'b1; use_start = 1'b1; end
            default: kind = HCNT_INT_DIR;
        endcase
    end

    assign rst_act      = use_rst & (pin.ext_reset ^ cfg_q.reset_low);
    assign rst_act_prev = use_rst & (pin_prev_q.ext_reset ^ cfg_q.reset_low);
    assign start_ok     = ~use_start | (pin.ext_start ^ cfg_q.start_low);
    assign active       = defined_q & sys_q[SYS_RUN];
    assign a_rise       = pin.phase_a & ~pin_prev_q.phase_a;
    assign b_rise       = pin.phase_b & ~pin_prev_q.phase_b;
    assign a_chg        = pin.phase_a ^ pin_prev_q.phase_a;
    assign b_chg        = pin.phase_b ^ pin_prev_q.phase_b;

    // ----------------------------------------------------------------
    // count steps per mode family
    // ----------------------------------------------------------------
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        unique case (kind)
            HCNT_INT_DIR: begin
                step_up = a_rise & dir_q;
                step_dn = a_rise & ~dir_q;
            end
            HCNT_EXT_DIR: begin
                step_up = a_rise & pin.phase_b;
                step_dn = a_rise & ~pin.phase_b;
            end
            HCNT_TWO_CLK: begin
                step_up = a_rise & ~b_rise;
                step_dn = b_rise & ~a_rise;
            end
            HCNT_QUAD: begin
                if (cfg_q.rate_1x) begin
                    step_up = a_rise & ~pin.phase_b;
                    step_dn = a_rise & pin.phase_b;
                end else begin
                    step_up = (a_chg ^ b_chg) & (pin.phase_a ^ pin_prev_q.phase_b);
                    step_dn = (a_chg ^ b_chg) & ~(pin.phase_a ^ pin_prev_q.phase_b);
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // counter core
    // ----------------------------------------------------------------
    always_comb begin
        count_d  = count_q;
        preset_d = preset_q;
        dir_d    = dir_q;
        if (upd_cmd) begin
            if (ctrl_q[CB_LOAD_CUR]) count_d = new_cur_q;
            if (ctrl_q[CB_LOAD_PRE]) preset_d = new_pre_q;
            if (ctrl_q[CB_DIR_UPD]) dir_d = ctrl_q[CB_DIR_UP];
        end else if (active && en_q) begin
            if (rst_act) begin
                count_d = 32'sh0000_0000;
            end else if (start_ok) begin
                if (step_up) count_d = count_q + 32'sh0000_0001;
                if (step_dn) count_d = count_q - 32'sh0000_0001;
            end
            if (kind == HCNT_EXT_DIR) begin
                dir_d = pin.phase_b;
            end else if (kind != HCNT_INT_DIR && start_ok && !rst_act) begin
                if (step_up) dir_d = 1'b1;
                if (step_dn) dir_d = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q    <= 32'sh0000_0000;
            preset_q   <= 32'sh0000_0000;
            dir_q      <= 1'b1;
            en_q       <= 1'b0;
            pin_prev_q <= '0;
        end else begin
            count_q    <= count_d;
            preset_q   <= preset_d;
            dir_q      <= dir_d;
            pin_prev_q <= pin;
            if (!sys_q[SYS_RUN]) begin
                en_q <= 1'b0;
            end else if (upd_cmd) begin
                en_q <= ctrl_q[CB_ENABLE];
            end
        end
    end

    // ----------------------------------------------------------------
    // compare status and events
    // ----------------------------------------------------------------
    assign eq_d   = (count_d == preset_d);
    assign ev_eq  = active & eq_d & ~eq_q;
    assign ev_dir = active & en_q & ~upd_cmd & (kind != HCNT_INT_DIR) & (dir_d != dir_q);
    assign ev_rst = active & en_q & rst_act & ~rst_act_prev;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eq_q           <= 1'b1;
            gt_q           <= 1'b0;
            evt_cv_eq_pv_o <= 1'b0;
            evt_dir_chg_o  <= 1'b0;
            evt_ext_rst_o  <= 1'b0;
        end else begin
            eq_q           <= eq_d;
            gt_q           <= count_d > preset_d;
            evt_cv_eq_pv_o <= ev_eq & sys_q[SYS_GIE] & sys_q[SYS_ATT_EQ];
            evt_dir_chg_o  <= ev_dir & sys_q[SYS_GIE] & sys_q[SYS_ATT_DIR];
            evt_ext_rst_o  <= ev_rst & sys_q[SYS_GIE] & sys_q[SYS_ATT_RST];
        end
    end

    // ----------------------------------------------------------------
    // axi read channel
    // ----------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = mapped(s_axi_araddr_i);
        unique case (s_axi_araddr_i)
            OFF_CTRL:    rd_word[7:0] = ctrl_q;
            OFF_NEW_CUR: rd_word = new_cur_q;
            OFF_NEW_PRE: rd_word = new_pre_q;
            OFF_SYS:     rd_word = sys_q;
            OFF_STATUS: begin
                rd_word[ST_DIR]              = dir_q;
                rd_word[ST_EQ]               = eq_q;
                rd_word[ST_GT]               = gt_q;
                rd_word[ST_DEFINED]          = defined_q;
                rd_word[ST_ERROR]            = err_q;
                rd_word[ST_ENABLED]          = en_q;
                rd_word[ST_MODE_LSB +: 4]    = cfg_q.mode;
            end
            OFF_CURRENT: rd_word = count_q;
            default:     rd_word = 32'h0000_0000;
        endcase
    end

    assign ar_take   = s_axi_arvalid_i & s_axi_arready_o;
    assign rvalid_nx = ar_take | (s_axi_rvalid_o & ~s_axi_rready_i);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= RESP_OKAY;
        end else begin
            s_axi_arready_o <= ~rvalid_nx;
            s_axi_rvalid_o  <= rvalid_nx;
            if (ar_take) begin
                s_axi_rdata_o <= rd_ok ? rd_word : 32'h0000_0000;
                s_axi_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end
endmodule

// ===== bench/hcnt_pins_model.sv
`timescale 1ns/1ps
module hcnt_pins_model (
    input  wire logic           mclk_i,
    output hcnt_pkg::hcnt_pins_t pins_o
);
    import hcnt_pkg::*;
    initial pins_o = 4'h4;
    // hold each level past the pin synchroniser and the event stage
    task automatic drive(input logic [3:0] v);
        @(posedge mclk_i);
        pins_o <= v;
        repeat (8) @(posedge mclk_i);
    endtask
endmodule

// ===== bench/hcnt_top_properties.sv
`timescale 1ns/1ps
module hcnt_top_properties (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic evt_cv_eq_pv_o,
    input wire logic evt_dir_chg_o,
    input wire logic evt_ext_rst_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_eq_evt_pulse: assert property (evt_cv_eq_pv_o |=> !evt_cv_eq_pv_o)
        else $error("eq event too long");
    a_dir_evt_pulse: assert property (evt_dir_chg_o |=> !evt_dir_chg_o)
        else $error("dir event too long");
    a_rst_evt_pulse: assert property (evt_ext_rst_o |=> !evt_ext_rst_o)
        else $error("reset event too long");
    a_wr_resp_time: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write answer late");
    a_rd_resp_time: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    a_b_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("bvalid kept");
    a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("arready during rvalid");
    a_aw_blocked: assert property (s_axi_bvalid_o |-> !(s_axi_awready_o || s_axi_wready_o))
        else $error("write ready during bvalid");
    c_eq: cover property (evt_cv_eq_pv_o);
    c_dir: cover property (evt_dir_chg_o);
    c_rst: cover property (evt_ext_rst_o);
endmodule
bind hcnt_top hcnt_top_properties u_props (.mclk_i, .rst_n_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .evt_cv_eq_pv_o, .evt_dir_chg_o,
    .evt_ext_rst_o);

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import hcnt_pkg::*;
    logic        mclk_i, rst_n_i, awv, wv, arv, br, rr;
    logic [3:0]  ws;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdat;
    logic [1:0]  rsp;
    logic [2:0]  seen;
    int          errors, samples_checked;
    hcnt_pins_t  pins;
    hcnt_pins_model pm (.mclk_i(mclk_i), .pins_o(pins));
    hcnt_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(), .s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i(br),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(), .s_axi_rdata_o(),
        .s_axi_rresp_o(), .s_axi_rvalid_o(), .s_axi_rready_i(rr), .pins_i(pins),
        .evt_cv_eq_pv_o(), .evt_dir_chg_o(), .evt_ext_rst_o());
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    // sticky record of event pulses
    always @(posedge mclk_i) seen <= seen | {dut.evt_ext_rst_o === 1'b1,
        dut.evt_dir_chg_o === 1'b1, dut.evt_cv_eq_pv_o === 1'b1};
    task finish_test;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s exp %h got %h", nm, e, s);
        end
    endtask
    task tmo(input int n);
        if (n >= 40) begin
            errors++;
            finish_test;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        logic tb = 1'b0;
        int   n = 0;
        @(posedge mclk_i);
        {awa, wd, awv, wv, br} <= {a, d, 3'b111};
        while (!tb && n < 40) begin
            @(negedge mclk_i);
            {ta, tw, tb, rsp} = {dut.s_axi_awready_o, dut.s_axi_wready_o, dut.s_axi_bvalid_o,
                dut.s_axi_bresp_o};
            @(posedge mclk_i);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) br <= 1'b0;
            n++;
        end
        tmo(n);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta;
        logic tv = 1'b0;
        int   n = 0;
        @(posedge mclk_i);
        {ara, arv, rr} <= {a, 2'b11};
        while (!tv && n < 40) begin
            @(negedge mclk_i);
            {ta, tv, rsp, rdat} = {dut.s_axi_arready_o, dut.s_axi_rvalid_o, dut.s_axi_rresp_o,
                dut.s_axi_rdata_o};
            @(posedge mclk_i);
            if (ta) arv <= 1'b0;
            if (tv) rr <= 1'b0;
            n++;
        end
        tmo(n);
    endtask
    task t_reset;
        rd(OFF_STATUS);
        chk("status", 32'(rdat[7:5]), 32'h3);
        rd(8'h20);
        chk("rresp", 32'(rsp), 32'(RESP_SLVERR));
        wr(8'h21, 32'h1);
        chk("bresp", 32'(rsp), 32'(RESP_SLVERR));
    endtask
    task t_modes;
        for (int m = 0; m < 12; m++) begin
            wr(OFF_SYS, 32'h0);
            wr(OFF_SYS, 32'h1);
            wr(OFF_DEFINE, 32'(m));
            rd(OFF_STATUS);
            chk("mode", 32'({rdat[8], rdat[19:16]}), 32'(16 + m));
        end
    endtask
    task t_once;
        wr(OFF_SYS, 32'h0);
        wr(OFF_SYS, 32'h0000_E003);
        wr(OFF_CTRL, 32'h0000_00F8);
        wr(OFF_NEW_CUR, 32'h1);
        wr(OFF_NEW_PRE, 32'h3);
        wr(OFF_DEFINE, 32'h4);
        wr(OFF_DEFINE, 32'h9);
        rd(OFF_STATUS);
        chk("redefine", 32'({rdat[9:8], rdat[19:16]}), 32'h34);
        rd(OFF_CURRENT);
        chk("staged", rdat, 32'h0);
        wr(OFF_UPDATE, 32'h0);
        rd(OFF_CURRENT);
        chk("loaded", rdat, 32'h1);
        rd(OFF_STATUS);
        chk("ctrl", 32'({rdat[10], rdat[7:5]}), 32'h9);
    endtask
    task t_count;
        repeat (2) begin
            pm.drive(4'hC);
            pm.drive(4'h4);
        end
        rd(OFF_CURRENT);
        chk("count", rdat, 32'h3);
        chk("eq event", 32'(seen), 32'h1);
        pm.drive(4'h0);
        chk("dir event", 32'(seen), 32'h3);
        pm.drive(4'h2);
        rd(OFF_CURRENT);
        chk("ext reset", rdat, 32'h0);
        chk("rst event", 32'(seen), 32'h7);
    endtask
    task t_quad;
        wr(OFF_SYS, 32'h0);
        wr(OFF_SYS, 32'h1);
        wr(OFF_CTRL, 32'h0000_00FC);
        wr(OFF_DEFINE, 32'h9);
        ws <= 4'h1;
        wr(OFF_NEW_CUR, 32'h0000_0105);
        ws <= 4'hF;
        wr(OFF_UPDATE, 32'h0);
        pm.drive(4'h8);
        pm.drive(4'hC);
        pm.drive(4'h4);
        pm.drive(4'h0);
        rd(OFF_CURRENT);
        chk("quad 1x", rdat, 32'h6);
    endtask
    initial begin
        {rst_n_i, awv, wv, arv, br, rr, awa, ara, wd, seen} = '0;
        ws = 4'hF;
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        t_reset;
        t_modes;
        t_once;
        t_count;
        t_quad;
        finish_test;
    end
endmodule
